// file: crp_cmd_register.sv
`timescale 1ns/10ps
`default_nettype none

// command fifo: valid/ready on both sides, drain may stall
module crp_fifo #(
   parameter int W = 26,
   parameter int DEPTH = 32
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } crp_fifo_st_t;

   crp_fifo_st_t q;
   crp_fifo_st_t d;
   logic push;
   logic pop;

   always_comb begin
      in_ready_o = (q.cnt != FULL_CNT);
      out_valid_o = (q.cnt != '0);
      out_data_o = q.mem[q.rd];
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      d = q;
      if (push) begin
         d.mem[q.wr] = in_data_i;
         d.wr = q.wr + 1'b1;
      end
      if (pop) begin
         d.rd = q.rd + 1'b1;
      end
      if (push && !pop) begin
         d.cnt = q.cnt + 1'b1;
      end else if (pop && !push) begin
         d.cnt = q.cnt - 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule // crp_fifo

// Function
// - strap high: two rank-select inputs, each output copied to left and right side.
// - strap low: four rank-select inputs drive four single-copy rank-select outputs.
// - all command, address and control inputs captured on the clock rising edge.
// - captured command forwarded only when exactly one rank select is low.
// - parity is even over module-independent inputs plus parity bit.
// - mismatch of parity against address, bank and strobes pulls fault output low when exactly one rank select is low.
// - clock-enable, termination and rank-select inputs excluded from parity.
// - reset clears registers, disables outputs including fault, holds clock-enable outputs low.
// - path is 28 duplicated bits, or 26 duplicated plus 4 single in quad mode.
module crp_cmd_register (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic quad_rank_strap_n_i,
   input wire logic [crp_pkg::ADDR_W-1:0] addr_in_i,
   input wire logic [crp_pkg::BANK_W-1:0] bank_sel_in_i,
   input wire logic row_strobe_in_i,
   input wire logic col_strobe_in_i,
   input wire logic write_en_in_i,
   input wire logic [crp_pkg::CKE_W-1:0] clk_en_in_i,
   input wire logic [crp_pkg::ODT_W-1:0] term_ctrl_in_i,
   input wire logic [crp_pkg::RANK_W-1:0] rank_select_in_n_i,
   input wire logic parity_bit_in_i,
   input wire logic out_stall_i,
   output logic [crp_pkg::ADDR_W-1:0] addr_out_left_o,
   output logic [crp_pkg::ADDR_W-1:0] addr_out_right_o,
   output logic [crp_pkg::BANK_W-1:0] bank_sel_out_left_o,
   output logic [crp_pkg::BANK_W-1:0] bank_sel_out_right_o,
   output logic [crp_pkg::STROBE_W-1:0] strobe_out_left_o,
   output logic [crp_pkg::STROBE_W-1:0] strobe_out_right_o,
   output logic [crp_pkg::CKE_W-1:0] clk_en_out_left_o,
   output logic [crp_pkg::CKE_W-1:0] clk_en_out_right_o,
   output logic [crp_pkg::ODT_W-1:0] term_ctrl_out_left_o,
   output logic [crp_pkg::ODT_W-1:0] term_ctrl_out_right_o,
   output logic [crp_pkg::PAIR_W-1:0] rank_select_out_left_n_o,
   output logic [crp_pkg::PAIR_W-1:0] rank_select_out_right_n_o,
   output logic [crp_pkg::RANK_W-1:0] rank_select_out_n_o,
   output logic cmd_out_oe_n_o,
   output logic parity_fault_n_o,
   output logic parity_fault_oe_n_o,
   output logic cmd_accept_o
);
   typedef struct packed {
      crp_pkg::crp_state_t st;
      logic quad;
      logic [crp_pkg::ADDR_W-1:0] a;
      logic [crp_pkg::BANK_W-1:0] ba;
      logic [crp_pkg::STROBE_W-1:0] strb;
      logic [crp_pkg::CKE_W-1:0] cke;
      logic [crp_pkg::ODT_W-1:0] odt;
      logic [crp_pkg::RANK_W-1:0] cs;
      logic par;
      logic [crp_pkg::ADDR_W-1:0] oa;
      logic [crp_pkg::BANK_W-1:0] oba;
      logic [crp_pkg::STROBE_W-1:0] ostrb;
      logic [crp_pkg::CKE_W-1:0] ocke;
      logic [crp_pkg::ODT_W-1:0] oodt;
      logic [crp_pkg::PAIR_W-1:0] ocs_l;
      logic [crp_pkg::PAIR_W-1:0] ocs_r;
      logic [crp_pkg::RANK_W-1:0] ocs_quad;
      logic oe_n;
      logic fault_n;
      logic accept;
   } crp_st_t;

   crp_st_t q;
   crp_st_t d;
   logic sel;
   logic odd;
   logic [crp_pkg::RANK_W-1:0] cs_eff;
   logic [crp_pkg::CMD_W-1:0] push_word;
   logic fifo_ready;
   logic fifo_valid;
   logic [crp_pkg::CMD_W-1:0] pop_word;

   // true when exactly one active rank select is low; upper pair ignored in dual mode
   function automatic logic one_low(input logic [crp_pkg::RANK_W-1:0] cs, input logic quad);
      logic [crp_pkg::RANK_W-1:0] act;
      act = ~cs;
      if (!quad) begin
         act[3:2] = 2'h0;
      end
      return (act != 4'h0) && ((act & (act - 4'h1)) == 4'h0);
   endfunction

   crp_fifo #(
      .W(crp_pkg::CMD_W),
      .DEPTH(crp_pkg::FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .in_valid_i(sel),
      .in_ready_o(fifo_ready),
      .in_data_i(push_word),
      .out_valid_o(fifo_valid),
      .out_ready_i(!out_stall_i),
      .out_data_o(pop_word)
   );

   always_comb begin
      sel = one_low(q.cs, q.quad);
      odd = ^{q.a, q.ba, q.strb, q.par};
      cs_eff = q.cs;
      if (!q.quad) begin
         cs_eff[3:2] = crp_pkg::PAIR_IDLE_N;
      end
      push_word = {cs_eff, q.strb, q.ba, q.a};
      d = q;
      // capture every command, address and control input on the rising edge
      d.a = addr_in_i;
      d.ba = bank_sel_in_i;
      d.strb = {row_strobe_in_i, col_strobe_in_i, write_en_in_i};
      d.cke = clk_en_in_i;
      d.odt = term_ctrl_in_i;
      d.cs = rank_select_in_n_i;
      d.par = parity_bit_in_i;
      case (q.st)
         crp_pkg::CRP_ST_RESET: begin
            // strap sampled once on the first edge after reset
            d.quad = !quad_rank_strap_n_i;
            d.st = crp_pkg::CRP_ST_RUN;
         end
         default: begin
            d.quad = q.quad;
         end
      endcase
      d.oe_n = crp_pkg::OE_ON_N;
      d.fault_n = !(sel && odd);
      d.accept = fifo_ready;
      d.ocke = q.cke;
      d.oodt = q.odt;
      d.ocs_l = crp_pkg::PAIR_IDLE_N;
      d.ocs_r = crp_pkg::PAIR_IDLE_N;
      d.ocs_quad = crp_pkg::RANK_IDLE_N;
      if (fifo_valid && !out_stall_i) begin
         {d.ostrb, d.oba, d.oa} = pop_word[crp_pkg::CMD_W-crp_pkg::RANK_W-1:0];
         if (q.quad) begin
            d.ocs_quad = pop_word[crp_pkg::CMD_W-1 -: crp_pkg::RANK_W];
         end else begin
            d.ocs_l = pop_word[crp_pkg::CMD_W-3 -: crp_pkg::PAIR_W];
            d.ocs_r = pop_word[crp_pkg::CMD_W-3 -: crp_pkg::PAIR_W];
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         q <= '0;
         q.cs <= crp_pkg::RANK_IDLE_N;
         q.ocs_l <= crp_pkg::PAIR_IDLE_N;
         q.ocs_r <= crp_pkg::PAIR_IDLE_N;
         q.ocs_quad <= crp_pkg::RANK_IDLE_N;
         q.oe_n <= crp_pkg::OE_OFF_N;
         q.fault_n <= crp_pkg::FAULT_IDLE_N;
      end else begin
         q <= d;
      end
   end

   always_comb begin
      addr_out_left_o = q.oa;
      addr_out_right_o = q.oa;
      bank_sel_out_left_o = q.oba;
      bank_sel_out_right_o = q.oba;
      strobe_out_left_o = q.ostrb;
      strobe_out_right_o = q.ostrb;
      clk_en_out_left_o = q.ocke;
      clk_en_out_right_o = q.ocke;
      term_ctrl_out_left_o = q.oodt;
      term_ctrl_out_right_o = q.oodt;
      rank_select_out_left_n_o = q.ocs_l;
      rank_select_out_right_n_o = q.ocs_r;
      rank_select_out_n_o = q.ocs_quad;
      cmd_out_oe_n_o = q.oe_n;
      parity_fault_n_o = crp_pkg::OD_LOW;
      parity_fault_oe_n_o = q.fault_n;
      cmd_accept_o = q.accept;
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   a_capture_rise_edge:
      assert property (q.st == crp_pkg::CRP_ST_RUN |=>
         q.a == $past(addr_in_i) && q.cs == $past(rank_select_in_n_i))
      else $error("inputs not captured on the rising edge");

   a_fault_on_odd:
      assert property (sel && odd |=> !parity_fault_oe_n_o && !parity_fault_n_o)
      else $error("odd parity did not pull fault low");

   a_even_parity_clean:
      assert property (sel |=> parity_fault_oe_n_o == !(^$past({addr_in_i, bank_sel_in_i,
         row_strobe_in_i, col_strobe_in_i, write_en_in_i, parity_bit_in_i}, 2)))
      else $error("fault does not follow even parity of covered inputs");

   a_fault_needs_rank:
      assert property (!sel |=> parity_fault_oe_n_o)
      else $error("fault asserted without a single rank select");

   a_forward_one_rank:
      assert property ($countones(~rank_select_out_n_o) <= 1 &&
         $countones(~rank_select_out_left_n_o) <= 1)
      else $error("more than one rank select forwarded");

   a_quad_single_copy:
      assert property (q.quad |-> rank_select_out_left_n_o == crp_pkg::PAIR_IDLE_N &&
         rank_select_out_right_n_o == crp_pkg::PAIR_IDLE_N)
      else $error("paired rank outputs active in quad mode");

   a_dual_copies_match:
      assert property (!q.quad |-> rank_select_out_left_n_o == rank_select_out_right_n_o &&
         rank_select_out_n_o == crp_pkg::RANK_IDLE_N && addr_out_left_o == addr_out_right_o)
      else $error("dual mode copies differ");

   a_strap_latched:
      assert property ($past(q.st) == crp_pkg::CRP_ST_RESET ##0 q.st == crp_pkg::CRP_ST_RUN
         |-> q.quad == !$past(quad_rank_strap_n_i) ##1 $stable(q.quad))
      else $error("strap not latched after reset");

   a_reset_outputs_off:
      assert property (disable iff (1'b0) reset_i |=> cmd_out_oe_n_o &&
         parity_fault_oe_n_o && clk_en_out_left_o == 2'h0 &&
         rank_select_out_n_o == crp_pkg::RANK_IDLE_N)
      else $error("outputs not disabled in reset");

   a_forward_latency:
      assert property (sel && fifo_ready && !fifo_valid ##1 !out_stall_i |=>
         (q.quad ? rank_select_out_n_o == $past(q.cs, 2) :
         rank_select_out_left_n_o == $past(q.cs[1:0], 2)) &&
         addr_out_left_o == $past(q.a, 2))
      else $error("qualified command not forwarded in two cycles");
endmodule // crp_cmd_register
`default_nettype wire

// file: crp_cmd_register_tb.sv
`timescale 1ns/10ps
`default_nettype none
module crp_cmd_register_tb;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic strap_n = 1'b1;
   logic stall = 1'b0;
   logic [15:0] a_in, a_l, a_r;
   logic [2:0] b_in, b_l, b_r, s_in, s_l, s_r;
   logic [1:0] k_in, k_l, k_r, t_in, t_l, t_r, r_l, r_r;
   logic [3:0] r_in, r_q;
   logic par, oe_n, f_n, f_oe_n, accept;
   int mismatches = 0;
   int total_checks = 0;
   always #20 sys_clk_i = ~sys_clk_i;
   crp_ctrl_model i_crp_ctrl_model (.addr_o(a_in), .bank_o(b_in), .strobe_o(s_in),
      .cke_o(k_in), .odt_o(t_in), .rank_n_o(r_in), .parity_o(par));
   crp_cmd_register i_crp_cmd_register (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .quad_rank_strap_n_i(strap_n), .addr_in_i(a_in), .bank_sel_in_i(b_in),
      .row_strobe_in_i(s_in[2]), .col_strobe_in_i(s_in[1]), .write_en_in_i(s_in[0]),
      .clk_en_in_i(k_in), .term_ctrl_in_i(t_in), .rank_select_in_n_i(r_in),
      .parity_bit_in_i(par), .out_stall_i(stall), .addr_out_left_o(a_l),
      .addr_out_right_o(a_r), .bank_sel_out_left_o(b_l), .bank_sel_out_right_o(b_r),
      .strobe_out_left_o(s_l), .strobe_out_right_o(s_r), .clk_en_out_left_o(k_l),
      .clk_en_out_right_o(k_r), .term_ctrl_out_left_o(t_l), .term_ctrl_out_right_o(t_r),
      .rank_select_out_left_n_o(r_l), .rank_select_out_right_n_o(r_r),
      .rank_select_out_n_o(r_q), .cmd_out_oe_n_o(oe_n), .parity_fault_n_o(f_n),
      .parity_fault_oe_n_o(f_oe_n), .cmd_accept_o(accept));
   task automatic step();
      @(posedge sys_clk_i);
      #1;
   endtask
   task automatic close_out();
      if (mismatches == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic do_reset(input logic mode_n);
      reset_i = 1'b1;
      strap_n = mode_n;
      repeat (12) step();
      chk(oe_n, 32'h1);
      chk({r_l, r_r, r_q, f_oe_n}, 32'h1ff);
      reset_i = 1'b0;
      step();
      step();
      chk(oe_n, 32'h0);
   endtask
   // one command, then the fault and forwarded outputs at their fixed edges
   task automatic cmd(input logic [3:0] rank_n, input logic [15:0] addr, input logic bad,
         input logic exp_f, input logic [1:0] exp_pair, input logic [3:0] exp_q);
      i_crp_ctrl_model.send(rank_n, addr, bad);
      step();
      i_crp_ctrl_model.idle();
      step();
      chk(f_oe_n, exp_f);
      step();
      chk({r_l, r_r}, {exp_pair, exp_pair});
      chk(r_q, exp_q);
      chk({k_l, k_r, t_l, t_r}, {addr[1:0], addr[1:0], ~addr[1:0], ~addr[1:0]});
      if (exp_pair !== 2'h3 || exp_q !== 4'hf) begin
         chk({a_l, a_r}, {addr, addr});
         chk({b_l, b_r, s_l, s_r}, {{2{addr[2:0] ^ 3'h5}}, {2{addr[5:3]}}});
      end
   endtask
   task automatic fifo_fill();
      int seen = 0;
      do_reset(1'b1);
      stall = 1'b1;
      for (int i = 0; i < 34; i++) begin
         i_crp_ctrl_model.send(4'he, i[15:0], 1'b0);
         step();
      end
      i_crp_ctrl_model.idle();
      step();
      step();
      chk(accept, 32'h0);
      stall = 1'b0;
      for (int i = 0; i < 80; i++) begin
         step();
         if (r_l === 2'h2) seen++;
      end
      chk(seen, crp_pkg::FIFO_DEPTH);
      chk(accept, 32'h1);
   endtask
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      mismatches++;
      close_out();
   end
   // dual mode from power-up: one, two and no rank selects, good and bad parity
   task automatic dual_cmds();
      do_reset(1'b1);
      chk(f_n, 32'h0);
      cmd(4'he, 16'h1234, 1'b0, 1'b1, 2'h2, 4'hf);
      cmd(4'hd, 16'h8001, 1'b1, 1'b0, 2'h1, 4'hf);
      cmd(4'hc, 16'h0007, 1'b1, 1'b1, 2'h3, 4'hf);
      cmd(4'hf, 16'h0102, 1'b1, 1'b1, 2'h3, 4'hf);
      cmd(4'h2, 16'h00f3, 1'b0, 1'b1, 2'h2, 4'hf);
   endtask
   // quad mode entered through a reset in mid-run
   task automatic quad_cmds();
      do_reset(1'b0);
      cmd(4'hb, 16'h4e2d, 1'b0, 1'b1, 2'h3, 4'hb);
      cmd(4'h7, 16'hffff, 1'b1, 1'b0, 2'h3, 4'h7);
      cmd(4'h3, 16'h0a0a, 1'b1, 1'b1, 2'h3, 4'hf);
   endtask
   initial begin
      dual_cmds();
      quad_cmds();
      fifo_fill();
      close_out();
   end
endmodule // crp_cmd_register_tb
`default_nettype wire

// file: crp_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// controller side: drives one command per call with even parity unless told otherwise
module crp_ctrl_model (
   output logic [crp_pkg::ADDR_W-1:0] addr_o,
   output logic [crp_pkg::BANK_W-1:0] bank_o,
   output logic [crp_pkg::STROBE_W-1:0] strobe_o,
   output logic [crp_pkg::CKE_W-1:0] cke_o,
   output logic [crp_pkg::ODT_W-1:0] odt_o,
   output logic [crp_pkg::RANK_W-1:0] rank_n_o,
   output logic parity_o
);
   initial begin
      addr_o = 16'h0000;
      bank_o = 3'h0;
      strobe_o = 3'h0;
      cke_o = 2'h0;
      odt_o = 2'h0;
      rank_n_o = crp_pkg::RANK_IDLE_N;
      parity_o = 1'h0;
   end
   task automatic send(input logic [3:0] rank_n, input logic [15:0] addr, input logic bad);
      addr_o = addr;
      bank_o = addr[2:0] ^ 3'h5;
      strobe_o = addr[5:3];
      cke_o = addr[1:0];
      odt_o = ~addr[1:0];
      rank_n_o = rank_n;
      parity_o = ^{addr_o, bank_o, strobe_o} ^ bad;
   endtask
   // no command: address lines keep moving so stale values never look valid
   task automatic idle();
      rank_n_o = crp_pkg::RANK_IDLE_N;
      addr_o = ~addr_o;
      parity_o = ^{addr_o, bank_o, strobe_o};
   endtask
endmodule // crp_ctrl_model
`default_nettype wire

// file: crp_pkg.sv
`default_nettype none
package crp_pkg;
   localparam int ADDR_W = 16;
   localparam int BANK_W = 3;
   localparam int STROBE_W = 3;
   localparam int RANK_W = 4;
   localparam int PAIR_W = 2;
   localparam int CKE_W = 2;
   localparam int ODT_W = 2;
   // queued command word: rank selects, strobes, bank, address
   localparam int CMD_W = RANK_W + STROBE_W + BANK_W + ADDR_W;
   localparam int FIFO_DEPTH = 32;
   localparam logic [RANK_W-1:0] RANK_IDLE_N = 4'hf;
   localparam logic [PAIR_W-1:0] PAIR_IDLE_N = 2'h3;
   localparam logic FAULT_IDLE_N = 1'h1;
   localparam logic OE_OFF_N = 1'h1;
   localparam logic OE_ON_N = 1'h0;
   localparam logic OD_LOW = 1'h0;

   typedef enum logic [0:0] {
      CRP_ST_RESET = 1'b0,
      CRP_ST_RUN = 1'b1
   } crp_state_t;
endpackage
`default_nettype wire
